// [omc_irq.sv]
`timescale 1ns/1ps
// Sticky interrupt status with enable and write-one-to-clear
module omc_irq
  import omc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic event_in,
  input wire logic clear_in,
  input wire logic enable_in,
  output logic pending,
  output logic irq
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else if (event_in) begin
      pending <= 1'b1;
    end else if (clear_in) begin
      pending <= 1'b0;
    end
  end

  // Level output, gated by enable
  assign irq = pending & enable_in;
endmodule

// [omc_meas_src.sv]
`timescale 1ns/1ps
module omc_meas_src
  import omc_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [21:0] val,
  output logic done,
  output logic [9:0] cnt,
  output logic [11:0] mean
);
  // Results valid only with the pulse, so late sampling shows
  always_ff @(posedge clk) begin
    done <= go;
    {cnt, mean} <= go ? val : ~{cnt, mean};
  end
endmodule

// [omc_pkg.sv]
// Behaviour
// - Phase A config holds a writable five-bit offset in bits 9:5.
// - Phase A config holds a writable five-bit range in bits 4:0.
// - Phase B config holds a writable five-bit offset in bits 9:5.
// - Phase B config holds a writable five-bit range in bits 4:0.
// - Bits 15:10 of both phase configs read zero, ignore writes, and all bits reset to zero.
// - Compensator register holds a writable four-bit DC current in bits 11:8.
// - Compensator register holds a writable seven-bit compensation in bits 6:0; bit 7 and 15:12 are read-only.
// - Count result is read-only with the ten-bit integrator value in 9:0 and the step size in 15:12.
// - Mean result is read-only with the twelve-bit mean in 11:0 and the step size in 15:12.
// - Interrupt register bit 0 enables, writing 1 to bit 1 clears the pending interrupt; bits 15:2 read-only.
// - Preamplifier config is a sixteen-bit writable word resetting to zero.
// - The reported step size comes from a four-bit one-hot startup setting.
package omc_pkg;
  // Register word indices; the bus byte address is four times the index
  localparam logic [7:0] OMC_OFF_PHASE_A = 8'h06;
  localparam logic [7:0] OMC_OFF_PHASE_B = 8'h08;
  localparam logic [7:0] OMC_OFF_COMP = 8'h0A;
  localparam logic [7:0] OMC_OFF_COUNT = 8'h0C;
  localparam logic [7:0] OMC_OFF_MEAN = 8'h0E;
  localparam logic [7:0] OMC_OFF_IRQ = 8'h10;
  localparam logic [7:0] OMC_OFF_PREAMP = 8'h12;
  // Own additions for the interrupt block
  localparam logic [7:0] OMC_OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OMC_OFF_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OMC_OFF_IRQ_ENABLE = 8'h28;
  localparam int OMC_OFFSET_LSB = 5;
  localparam int OMC_RANGE_LSB = 0;
  localparam int OMC_DC_LSB = 8;
  localparam int OMC_COMP_LSB = 0;
  localparam int OMC_STEP_LSB = 12;
  localparam int OMC_IRQ_EN_BIT = 0;
  localparam int OMC_IRQ_CLR_BIT = 1;
  localparam int OMC_IRQ_STATUS_BIT = 0;
  localparam logic [15:0] OMC_RESET_VALUE = 16'h0000;
  localparam logic [15:0] OMC_PHASE_MASK = 16'h03FF;
  localparam logic [15:0] OMC_COMP_MASK = 16'h0F7F;
  localparam logic [1:0] OMC_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [4:0] offset;
    logic [4:0] phase_range;
  } omc_phase_t;

  typedef struct packed {
    logic [3:0] comp_dc_current;
    logic [6:0] comp_offset;
  } omc_comp_t;

  typedef struct packed {
    logic done;
    logic [9:0] count;
    logic [11:0] mean;
    logic [3:0] integrator_step_size;
  } omc_result_t;

  typedef enum logic [1:0] {
    OMC_IDLE = 2'b01,
    OMC_DATA = 2'b10
  } omc_phase_state_t;
endpackage

// [omc_regs.sv]
`timescale 1ns/1ps
module omc_regs
  import omc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic MEAS_DONE,
  input wire logic [9:0] MEAS_COUNT,
  input wire logic [11:0] MEAS_MEAN,
  input wire logic [3:0] STEP_SIZE,
  output logic [4:0] PHASE_A_OFFSET,
  output logic [4:0] PHASE_A_RANGE,
  output logic [4:0] PHASE_B_OFFSET,
  output logic [4:0] PHASE_B_RANGE,
  output logic [3:0] COMP_DC_CURRENT,
  output logic [6:0] COMP_OFFSET,
  output logic [15:0] PREAMP_CFG,
  output logic IRQ
);
  omc_phase_t phase_a;
  omc_phase_t phase_b;
  omc_comp_t comp;
  omc_result_t result;
  logic [15:0] preamp;
  logic irq_enable;
  logic irq_pending;
  logic irq_clear;
  logic [7:0] addr_q;
  logic wr_q;
  logic [15:0] wdata;
  logic [15:0] next_rdata;
  logic [3:0] step_latched;
  omc_phase_state_t state;
  // Slot taken this cycle, and its word index
  logic take;
  logic rd_take;
  logic [7:0] addr_index;
  // Per-register write strobes, data phase only
  logic wr_phase_a;
  logic wr_phase_b;
  logic wr_comp;
  logic wr_preamp;
  logic wr_irq_ctrl;
  logic wr_irq_clear;
  logic wr_irq_enable;
  // Next values of the stored registers
  omc_phase_t next_phase_a;
  omc_phase_t next_phase_b;
  omc_comp_t next_comp;
  logic [15:0] next_preamp;
  logic next_irq_enable;
  logic [3:0] next_step;
  omc_result_t next_result;

  // Word index of a byte address; every register is one aligned word, so the low two bits drop
  function automatic logic [7:0] omc_word_index(input logic [31:0] byte_addr);
    omc_word_index = {2'b00, byte_addr[7:2]};
  endfunction

  // A slot counts only when selected, ready and non-sequential; bursts are not supported
  function automatic logic omc_taken(input logic sel, input logic ready, input logic [1:0] trans);
    omc_taken = sel & ready & (trans == OMC_HTRANS_NONSEQ);
  endfunction

  // Pack a phase config; the six upper bits have no storage
  function automatic logic [15:0] omc_phase_word(input omc_phase_t p);
    omc_phase_word = 16'h0000 | (16'(p.offset) << OMC_OFFSET_LSB) | (16'(p.phase_range) << OMC_RANGE_LSB);
  endfunction

  // Unpack a phase config from a written word
  function automatic omc_phase_t omc_phase_field(input logic [15:0] d);
    omc_phase_field.offset = d[OMC_OFFSET_LSB +: 5];
    omc_phase_field.phase_range = d[OMC_RANGE_LSB +: 5];
  endfunction

  // Result word: step size on top, measured value below
  function automatic logic [15:0] omc_result_word(input logic [3:0] step, input logic [11:0] value);
    omc_result_word = (16'(step) << OMC_STEP_LSB) | 16'(value);
  endfunction

  // Slot decode shared by the address capture and the read path
  // Transfer size is ignored: only whole words are expected
  assign take = omc_taken(HSEL, HREADY, HTRANS);
  assign rd_take = take & !HWRITE;
  assign addr_index = omc_word_index(HADDR);

  // Address phase captured whenever the bus is ready
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
    end else if (HREADY) begin
      addr_q <= addr_index;
      wr_q <= take & HWRITE;
    end
  end

  // Transfer state; a write lands only in its own data phase
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state <= OMC_IDLE;
    end else if (HREADY) begin
      state <= take ? OMC_DATA : OMC_IDLE;
    end
  end

  // Zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign wdata = HWDATA[15:0];

  // Write strobes from the captured index; read-only words get none
  assign wr_phase_a = wr_q && (state == OMC_DATA) && (addr_q == OMC_OFF_PHASE_A);
  assign wr_phase_b = wr_q && (state == OMC_DATA) && (addr_q == OMC_OFF_PHASE_B);
  assign wr_comp = wr_q && (state == OMC_DATA) && (addr_q == OMC_OFF_COMP);
  assign wr_preamp = wr_q && (state == OMC_DATA) && (addr_q == OMC_OFF_PREAMP);
  assign wr_irq_ctrl = wr_q && (state == OMC_DATA) && (addr_q == OMC_OFF_IRQ);
  assign wr_irq_clear = wr_q && (state == OMC_DATA) && (addr_q == OMC_OFF_IRQ_CLEAR);
  assign wr_irq_enable = wr_q && (state == OMC_DATA) && (addr_q == OMC_OFF_IRQ_ENABLE);

  // Phase A next value, held unless written
  always_comb begin
    next_phase_a = phase_a;
    if (wr_phase_a) begin
      next_phase_a = omc_phase_field(wdata);
    end
  end

  // Phase B next value, held unless written
  always_comb begin
    next_phase_b = phase_b;
    if (wr_phase_b) begin
      next_phase_b = omc_phase_field(wdata);
    end
  end

  // Phase A store, upper bits have no storage
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      phase_a <= '0;
    end else begin
      phase_a <= next_phase_a;
    end
  end

  // Phase B store, same layout as phase A
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      phase_b <= '0;
    end else begin
      phase_b <= next_phase_b;
    end
  end

  // Compensation emitter next value; bit 7 and the top nibble are not stored
  always_comb begin
    next_comp = comp;
    if (wr_comp) begin
      next_comp.comp_dc_current = wdata[OMC_DC_LSB +: 4];
      next_comp.comp_offset = wdata[OMC_COMP_LSB +: 7];
    end
  end

  // Compensation emitter settings
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      comp <= '0;
    end else begin
      comp <= next_comp;
    end
  end

  // Preamplifier next value; bit meanings belong to the analog side
  always_comb begin
    next_preamp = preamp;
    if (wr_preamp) begin
      next_preamp = wdata;
    end
  end

  // Preamplifier store
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      preamp <= OMC_RESET_VALUE;
    end else begin
      preamp <= next_preamp;
    end
  end

  // Enable shared by the control word and the enable register
  always_comb begin
    next_irq_enable = irq_enable;
    if (wr_irq_ctrl || wr_irq_enable) begin
      next_irq_enable = wdata[OMC_IRQ_EN_BIT];
    end
  end

  // Interrupt enable store
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      irq_enable <= 1'b0;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  // Startup step size only accepted when one-hot, else last good kept
  always_comb begin
    next_step = step_latched;
    if ($onehot(STEP_SIZE)) begin
      next_step = STEP_SIZE;
    end
  end

  // Step size store
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      step_latched <= 4'h0;
    end else begin
      step_latched <= next_step;
    end
  end

  // Results snapshot at measurement end so reads stay coherent
  always_comb begin
    next_result = result;
    if (MEAS_DONE) begin
      next_result.count = MEAS_COUNT;
      next_result.mean = MEAS_MEAN;
      next_result.integrator_step_size = step_latched;
      next_result.done = 1'b1;
    end
  end

  // Result store
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      result <= '0;
    end else begin
      result <= next_result;
    end
  end

  // Clear on a written one: bit 1 of the control word, or the status position of the clear register
  // A measurement end in the same cycle still wins inside the flag
  assign irq_clear = (wr_irq_ctrl && wdata[OMC_IRQ_CLR_BIT])
                     || (wr_irq_clear && wdata[OMC_IRQ_STATUS_BIT]);

  omc_irq u_irq (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .event_in(MEAS_DONE),
    .clear_in(irq_clear),
    .enable_in(irq_enable),
    .pending(irq_pending),
    .irq(IRQ)
  );

  // Read mux on the live word index, unmapped words read as zero
  always_comb begin
    next_rdata = 16'h0000;
    unique case (addr_index)
      OMC_OFF_PHASE_A: next_rdata = omc_phase_word(phase_a) & OMC_PHASE_MASK;
      OMC_OFF_PHASE_B: next_rdata = omc_phase_word(phase_b) & OMC_PHASE_MASK;
      OMC_OFF_COMP: next_rdata = (16'(comp.comp_dc_current) << OMC_DC_LSB) | 16'(comp.comp_offset);
      OMC_OFF_COUNT: next_rdata = omc_result_word(result.integrator_step_size, {2'b00, result.count});
      OMC_OFF_MEAN: next_rdata = omc_result_word(result.integrator_step_size, result.mean);
      OMC_OFF_IRQ: next_rdata = 16'(irq_enable) << OMC_IRQ_EN_BIT;
      OMC_OFF_PREAMP: next_rdata = preamp;
      // Clear register is write-only and falls to the default
      OMC_OFF_IRQ_STATUS: next_rdata = 16'(irq_pending) << OMC_IRQ_STATUS_BIT;
      OMC_OFF_IRQ_ENABLE: next_rdata = 16'(irq_enable) << OMC_IRQ_EN_BIT;
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (rd_take) begin
      HRDATA <= {16'h0000, next_rdata};
    end
  end

  // Configuration drives the analog front end
  assign PHASE_A_OFFSET = phase_a.offset;
  assign PHASE_A_RANGE = phase_a.phase_range;
  assign PHASE_B_OFFSET = phase_b.offset;
  assign PHASE_B_RANGE = phase_b.phase_range;
  assign COMP_DC_CURRENT = comp.comp_dc_current;
  assign COMP_OFFSET = comp.comp_offset;
  assign PREAMP_CFG = preamp;
endmodule

// [omc_regs_assertions.sv]
`timescale 1ns/1ps
// Port-level checks of the register bank
module omc_regs_chk
  import omc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic MEAS_DONE,
  input wire logic [4:0] PHASE_A_OFFSET,
  input wire logic [4:0] PHASE_A_RANGE,
  input wire logic [6:0] COMP_OFFSET,
  input wire logic [15:0] PREAMP_CFG,
  input wire logic IRQ
);
  logic wr_ph;
  logic [7:0] addr_q;
  // Write data phase marker; the writable config registers only change behind it
  always_ff @(posedge SYS_CLK) begin
    wr_ph <= RST_N && HSEL && HREADY && HTRANS == OMC_HTRANS_NONSEQ && HWRITE;
    addr_q <= {2'b00, HADDR[7:2]};
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_wr(a);
    wr_ph && addr_q == a;
  endsequence
  sequence s_rd(a);
    HSEL && HREADY && HTRANS == OMC_HTRANS_NONSEQ && !HWRITE && {2'b00, HADDR[7:2]} == a;
  endsequence
  a_phase_write: assert property (s_wr(OMC_OFF_PHASE_A) |=>
    {PHASE_A_OFFSET, PHASE_A_RANGE} == $past(HWDATA[9:0])) else $error("phase write lost");
  a_phase_read: assert property (s_rd(OMC_OFF_PHASE_A) |=>
    HRDATA == {22'h0, $past(PHASE_A_OFFSET), $past(PHASE_A_RANGE)}) else $error("phase read bad");
  a_comp_write: assert property (s_wr(OMC_OFF_COMP) |=>
    COMP_OFFSET == $past(HWDATA[6:0])) else $error("comp write lost");
  a_preamp_write: assert property (s_wr(OMC_OFF_PREAMP) |=>
    PREAMP_CFG == $past(HWDATA[15:0])) else $error("preamp write lost");
  a_cfg_hold: assert property (!wr_ph |=>
    $stable(PREAMP_CFG) && $stable(COMP_OFFSET)) else $error("config moved");
  a_irq_hold: assert property (IRQ && !wr_ph |=> IRQ) else $error("irq dropped");
  a_irq_clear: assert property (s_wr(OMC_OFF_IRQ) ##0 (HWDATA[1] && !MEAS_DONE) |=>
    !IRQ) else $error("irq not cleared");
  a_status_clear: assert property (s_wr(OMC_OFF_IRQ_CLEAR) ##0 (HWDATA[0] && !MEAS_DONE) |=>
    !IRQ) else $error("irq not cleared by clear register");
  a_irq_rise: assert property ($rose(IRQ) |->
    $past(MEAS_DONE) || $past(wr_ph)) else $error("irq without cause");
endmodule
bind omc_regs omc_regs_chk i_omc_regs_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
  .HRDATA(HRDATA), .MEAS_DONE(MEAS_DONE), .PHASE_A_OFFSET(PHASE_A_OFFSET),
  .PHASE_A_RANGE(PHASE_A_RANGE), .COMP_OFFSET(COMP_OFFSET), .PREAMP_CFG(PREAMP_CFG), .IRQ(IRQ));

// [tb_optical_measure_config_regs.sv]
`timescale 1ns/1ps
module tb_optical_measure_config_regs
  import omc_pkg::*;
;
  logic SYS_CLK = 1'h0;
  logic RST_N, HSEL, HWRITE, HREADYOUT, HRESP, MEAS_DONE, IRQ, go;
  logic [1:0] HTRANS;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [9:0] MEAS_COUNT;
  logic [11:0] MEAS_MEAN;
  logic [3:0] STEP_SIZE, dc;
  logic [4:0] pa_off, pa_rng, pb_off, pb_rng;
  logic [6:0] co;
  logic [15:0] pre;
  logic [21:0] val;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  omc_regs i_omc_regs (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MEAS_DONE(MEAS_DONE), .MEAS_COUNT(MEAS_COUNT),
    .MEAS_MEAN(MEAS_MEAN), .STEP_SIZE(STEP_SIZE), .PHASE_A_OFFSET(pa_off), .PHASE_A_RANGE(pa_rng),
    .PHASE_B_OFFSET(pb_off), .PHASE_B_RANGE(pb_rng), .COMP_DC_CURRENT(dc), .COMP_OFFSET(co),
    .PREAMP_CFG(pre), .IRQ(IRQ));
  omc_meas_src i_omc_meas_src (.clk(SYS_CLK), .go(go), .val(val), .done(MEAS_DONE),
    .cnt(MEAS_COUNT), .mean(MEAS_MEAN));
  task automatic results;
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  // Waits on the slave, never on a fixed count
  task automatic hwait;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    HSEL <= 1'h1;
    HTRANS <= OMC_HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {22'h0, a, 2'h0}; // Word index to byte address
    hwait();
    HTRANS <= 2'h0;
    HWDATA <= d;
    hwait();
    r = HRDATA;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    xfer(1'h1, a, d, r);
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    xfer(1'h0, a, 32'hFFFF, r);
    chk("read", e, r);
  endtask
  task automatic meas(logic [21:0] v);
    go <= 1'h1;
    val <= v;
    @(posedge SYS_CLK);
    go <= 1'h0;
    repeat (2) @(posedge SYS_CLK);
  endtask
  task automatic t_reset;
    logic [7:0] offs [8] = '{8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h14};
    foreach (offs[i]) rc(offs[i], 32'h0);
  endtask
  task automatic t_fields;
    wr(8'h06, 32'hFFE1);
    wr(8'h08, 32'hFC3E);
    wr(8'h0A, 32'h5AA5);
    wr(8'h12, 32'hFFFFA5C3);
    rc(8'h06, 32'h03E1);
    rc(8'h08, 32'h003E);
    rc(8'h0A, 32'h0A25);
    rc(8'h12, 32'hA5C3);
    chk("ports", 32'h3E1003E, {pa_off, pa_rng, 6'h0, pb_off, pb_rng});
    chk("comp", 32'hA25A5C3, {dc, 1'h0, co, pre});
  endtask
  task automatic t_meas;
    STEP_SIZE <= 4'h4;
    meas({10'h2AB, 12'hABC});
    wr(8'h0C, 32'hFFFF);
    rc(8'h0C, 32'h42AB);
    rc(8'h0E, 32'h4ABC);
    STEP_SIZE <= 4'h3;
    meas({10'h155, 12'h543});
    rc(8'h0C, 32'h4155);
  endtask
  task automatic t_irq;
    wr(8'h10, 32'h1);
    rc(8'h10, 32'h1);
    meas(22'h0);
    chk("irq", 32'h1, {31'h0, IRQ});
    wr(8'h10, 32'h3);
    rc(8'h20, 32'h0);
    chk("irq", 32'h0, {31'h0, IRQ});
    wr(8'h10, 32'h0);
    meas(22'h0);
    rc(8'h20, 32'h1);
    chk("irq", 32'h0, {31'h0, IRQ});
    wr(8'h28, 32'h1);
    @(posedge SYS_CLK);
    chk("irq", 32'h1, {31'h0, IRQ});
    wr(8'h24, 32'h1);
    rc(8'h10, 32'h1);
    chk("irq", 32'h0, {31'h0, IRQ});
  endtask
  // Main sequence
  initial begin
    RST_N = 1'h0;
    HSEL = 1'h0;
    HTRANS = 2'h0;
    HWRITE = 1'h0;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    go = 1'h0;
    val = 22'h0;
    STEP_SIZE = 4'h0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'h1;
    t_reset();
    t_fields();
    t_meas();
    t_irq();
    results();
  end
endmodule
